// ### common/pcd_pkg.sv
// Contract
// RL1: Enable from shutdown holds channels at zero
// RL2: First falling edge sets full scale
// RL3: Each further falling edge lowers one step
// RL4: Thirty-second pulse drives setting to zero
// RL5: Edge at zero wraps to full scale
// RL6: Long continuous low enters shutdown
// RL7: Shutdown puts all sinks high impedance
// RL8: Host holds pin high before pulsing
// RL9: Host low pulse stays within window
// RL10: Host keeps minimum high between pulses
// RL11: Pulse rate stays within supported band
// RL12: Undervoltage disables all channels
// RL13: Pump starts in 1x mode
// RL14: Lost regulation switches 1.5x after delay
// RL15: Overtemperature disables outputs until cooled
// RL16: Channel tied to pump output disabled
// RL17: Pin synchronised, edges detected, timer restarts
package pcd_pkg;

  localparam int unsigned PCD_NUM_CH = 4;
  localparam int unsigned PCD_LEVEL_W = 5;
  localparam logic [4:0] PCD_LEVEL_FULL = 5'h1F;
  localparam logic [4:0] PCD_LEVEL_ZERO = 5'h00;
  localparam logic [4:0] PCD_LEVEL_STEP = 5'h01;

  localparam int unsigned PCD_CLK_PERIOD_PS = 4000;

  // Least times, rounded up to whole cycles
  localparam int unsigned PCD_T_OFF_NS = 1500000;
  localparam int unsigned PCD_OFF_CYC = (PCD_T_OFF_NS * 1000 + PCD_CLK_PERIOD_PS - 1) / PCD_CLK_PERIOD_PS;
  localparam int unsigned PCD_T_SETUP_NS = 10000;
  localparam int unsigned PCD_SETUP_CYC = (PCD_T_SETUP_NS * 1000 + PCD_CLK_PERIOD_PS - 1) / PCD_CLK_PERIOD_PS;
  localparam int unsigned PCD_T_LO_MIN_NS = 300;
  localparam int unsigned PCD_LO_MIN_CYC = (PCD_T_LO_MIN_NS * 1000 + PCD_CLK_PERIOD_PS - 1) / PCD_CLK_PERIOD_PS;
  localparam int unsigned PCD_T_HI_MIN_NS = 300;
  localparam int unsigned PCD_HI_MIN_CYC = (PCD_T_HI_MIN_NS * 1000 + PCD_CLK_PERIOD_PS - 1) / PCD_CLK_PERIOD_PS;
  // Longest time, rounded down
  localparam int unsigned PCD_T_LO_MAX_NS = 200000;
  localparam int unsigned PCD_LO_MAX_CYC = (PCD_T_LO_MAX_NS * 1000) / PCD_CLK_PERIOD_PS;
  // Fixed delay before the pump steps up
  localparam int unsigned PCD_T_PUMP_NS = 400000;
  localparam int unsigned PCD_PUMP_CYC = (PCD_T_PUMP_NS * 1000) / PCD_CLK_PERIOD_PS;

  // Host default pulse shape: 1 us low, 1 us high, 500 kHz
  localparam int unsigned PCD_T_HOST_LO_NS = 1000;
  localparam int unsigned PCD_HOST_LO_CYC = (PCD_T_HOST_LO_NS * 1000 + PCD_CLK_PERIOD_PS - 1) / PCD_CLK_PERIOD_PS;
  localparam int unsigned PCD_T_HOST_HI_NS = 1000;
  localparam int unsigned PCD_HOST_HI_CYC = (PCD_T_HOST_HI_NS * 1000 + PCD_CLK_PERIOD_PS - 1) / PCD_CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    PCD_DEV_SHUTDOWN = 2'b00,
    PCD_DEV_WAIT_EDGE = 2'b01,
    PCD_DEV_DIMMING = 2'b10
  } pcd_dev_state_t;

  typedef enum logic [2:0] {
    PCD_HOST_OFF = 3'b000,
    PCD_HOST_SETUP = 3'b001,
    PCD_HOST_IDLE = 3'b010,
    PCD_HOST_LOW = 3'b011,
    PCD_HOST_GAP = 3'b100,
    PCD_HOST_HOLD_OFF = 3'b101
  } pcd_host_state_t;

endpackage : pcd_pkg

// ### common/pcd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcd_link_if;
  logic enable_dim_pin;
  modport host_end (output enable_dim_pin);
  modport device_end (input enable_dim_pin);
endinterface : pcd_link_if
`default_nettype wire

// ### rtl/pcd_device.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_device
  import pcd_pkg::*;
#(
  parameter int unsigned NUM_CH = PCD_NUM_CH,
  parameter int unsigned OFF_CYC = PCD_OFF_CYC,
  parameter int unsigned PUMP_CYC = PCD_PUMP_CYC
)(
  input wire logic clk,
  input wire logic sys_rst,
  pcd_link_if.device_end link,
  input wire logic supply_input_low,
  input wire logic over_temp,
  input wire logic regulation_ok,
  input wire logic [NUM_CH-1:0] sink_tied_to_pump_output,
  output logic [NUM_CH-1:0][4:0] sink_level_ma,
  output logic [NUM_CH-1:0] sink_hiz,
  output logic pump_mode_1p5x,
  output logic device_enabled,
  output logic [4:0] level_setting
);

  localparam int OFF_W = $clog2(OFF_CYC + 1);
  localparam int PUMP_W = $clog2(PUMP_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_d_reg;
  logic [2:0] misc_s1_reg;
  logic [2:0] misc_s2_reg;
  logic [NUM_CH-1:0] tied_s1_reg;
  logic [NUM_CH-1:0] tied_s2_reg;

  // RL17: synchronise pin
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= link.enable_dim_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      misc_s1_reg <= 3'h0;
      misc_s2_reg <= 3'h0;
      tied_s1_reg <= '0;
      tied_s2_reg <= '0;
    end
    else
    begin
      misc_s1_reg <= {regulation_ok, over_temp, supply_input_low};
      misc_s2_reg <= misc_s1_reg;
      tied_s1_reg <= sink_tied_to_pump_output;
      tied_s2_reg <= tied_s1_reg;
    end
  end

  logic uvlo_s;
  logic otemp_s;
  logic reg_ok_s;
  logic pin_fall;
  assign uvlo_s = misc_s2_reg[0];
  assign otemp_s = misc_s2_reg[1];
  assign reg_ok_s = misc_s2_reg[2];
  // RL11: edges at any rate
  // RL17: falling edge from synchronised pin
  assign pin_fall = pin_d_reg & ~pin_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Low-time shutdown timer

  logic [OFF_W-1:0] low_cnt_reg;
  logic off_hit;
  assign off_hit = (low_cnt_reg == OFF_W'(OFF_CYC));

  // RL17: timer restarts while pin high
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      low_cnt_reg <= '0;
    else if (pin_s2_reg)
      low_cnt_reg <= '0;
    else if (!off_hit)
      low_cnt_reg <= low_cnt_reg + OFF_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable state and dimming level

  pcd_dev_state_t state_reg;
  logic [4:0] level_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= PCD_DEV_SHUTDOWN;
    else
    begin
      case (state_reg)
        PCD_DEV_SHUTDOWN:
          // RL1: pin high enables
          if (pin_s2_reg)
            state_reg <= PCD_DEV_WAIT_EDGE;
        PCD_DEV_WAIT_EDGE:
          // RL6: long low shuts down
          if (off_hit)
            state_reg <= PCD_DEV_SHUTDOWN;
          else if (pin_fall)
            state_reg <= PCD_DEV_DIMMING;
        PCD_DEV_DIMMING:
          // RL6: long low shuts down
          if (off_hit)
            state_reg <= PCD_DEV_SHUTDOWN;
        default:
          state_reg <= PCD_DEV_SHUTDOWN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      level_reg <= PCD_LEVEL_ZERO;
    else if (state_reg == PCD_DEV_SHUTDOWN)
      // RL1: zero until first edge
      level_reg <= PCD_LEVEL_ZERO;
    else if (pin_fall && !off_hit)
    begin
      // RL2: first edge full scale
      if (state_reg == PCD_DEV_WAIT_EDGE)
        level_reg <= PCD_LEVEL_FULL;
      // RL5: wrap at zero
      else if (level_reg == PCD_LEVEL_ZERO)
        level_reg <= PCD_LEVEL_FULL;
      // RL3: one step down, reaching zero on pulse 32 (RL4)
      else
        level_reg <= level_reg - PCD_LEVEL_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge pump mode

  logic [PUMP_W-1:0] pump_cnt_reg;
  logic pump_1p5_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pump_cnt_reg <= '0;
      pump_1p5_reg <= 1'b0;
    end
    // RL13: restart in 1x
    else if (state_reg == PCD_DEV_SHUTDOWN)
    begin
      pump_cnt_reg <= '0;
      pump_1p5_reg <= 1'b0;
    end
    else if (!pump_1p5_reg)
    begin
      if (reg_ok_s)
        pump_cnt_reg <= '0;
      // RL14: step up after delay
      else if (pump_cnt_reg == PUMP_W'(PUMP_CYC - 1))
        pump_1p5_reg <= 1'b1;
      else
        pump_cnt_reg <= pump_cnt_reg + PUMP_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic active;
  assign active = (state_reg != PCD_DEV_SHUTDOWN);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          sink_level_ma[gi] <= PCD_LEVEL_ZERO;
          sink_hiz[gi] <= 1'b1;
        end
        else
        begin
          // RL7: shutdown high impedance
          sink_hiz[gi] <= !active;
          // RL12: undervoltage off; RL15: hot off; RL16: tied channel off
          if (!active || uvlo_s || otemp_s || tied_s2_reg[gi])
            sink_level_ma[gi] <= PCD_LEVEL_ZERO;
          else
            sink_level_ma[gi] <= level_reg;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pump_mode_1p5x <= 1'b0;
      device_enabled <= 1'b0;
      level_setting <= PCD_LEVEL_ZERO;
    end
    else
    begin
      pump_mode_1p5x <= pump_1p5_reg;
      device_enabled <= active;
      level_setting <= level_reg;
    end
  end

endmodule : pcd_device
`default_nettype wire

// ### rtl/pcd_host.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_host
  import pcd_pkg::*;
#(
  parameter int unsigned SETUP_CYC = PCD_SETUP_CYC,
  parameter int unsigned LO_CYC = PCD_HOST_LO_CYC,
  parameter int unsigned HI_CYC = PCD_HOST_HI_CYC,
  parameter int unsigned OFF_CYC = PCD_OFF_CYC
)(
  input wire logic clk,
  input wire logic sys_rst,
  pcd_link_if.host_end link,
  input wire logic cmd_valid,
  input wire logic cmd_shutdown,
  input wire logic [5:0] cmd_pulses,
  output logic cmd_ready,
  output logic link_on
);

  localparam int CW = $clog2(OFF_CYC + SETUP_CYC + 1);

  pcd_host_state_t state_reg;
  logic [CW-1:0] cnt_reg;
  logic [5:0] left_reg;
  logic pin_reg;

  assign link.enable_dim_pin = pin_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= PCD_HOST_OFF;
      cnt_reg <= '0;
      left_reg <= 6'h00;
      pin_reg <= 1'b0;
      cmd_ready <= 1'b0;
      link_on <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + CW'(1);
      case (state_reg)
        PCD_HOST_OFF, PCD_HOST_IDLE:
        begin
          cmd_ready <= 1'b1;
          cnt_reg <= '0;
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            left_reg <= cmd_pulses;
            if (cmd_shutdown)
            begin
              pin_reg <= 1'b0;
              state_reg <= PCD_HOST_HOLD_OFF;
            end
            else if (state_reg == PCD_HOST_OFF)
            begin
              pin_reg <= 1'b1;
              state_reg <= PCD_HOST_SETUP;
            end
            else if (cmd_pulses != 6'h00)
            begin
              pin_reg <= 1'b0;
              state_reg <= PCD_HOST_LOW;
            end
          end
        end
        PCD_HOST_SETUP:
          // RL8: setup high time
          if (cnt_reg == CW'(SETUP_CYC - 1))
          begin
            cnt_reg <= '0;
            link_on <= 1'b1;
            if (left_reg != 6'h00)
            begin
              pin_reg <= 1'b0;
              state_reg <= PCD_HOST_LOW;
            end
            else
              state_reg <= PCD_HOST_IDLE;
          end
        PCD_HOST_LOW:
          // RL9: bounded low pulse; RL11: pulse rate
          if (cnt_reg == CW'(LO_CYC - 1))
          begin
            cnt_reg <= '0;
            pin_reg <= 1'b1;
            left_reg <= left_reg - 6'h01;
            state_reg <= PCD_HOST_GAP;
          end
        PCD_HOST_GAP:
          // RL10: minimum high gap
          if (cnt_reg == CW'(HI_CYC - 1))
          begin
            cnt_reg <= '0;
            if (left_reg != 6'h00)
            begin
              pin_reg <= 1'b0;
              state_reg <= PCD_HOST_LOW;
            end
            else
              state_reg <= PCD_HOST_IDLE;
          end
        PCD_HOST_HOLD_OFF:
          // RL6: hold low for shutdown
          if (cnt_reg == CW'(OFF_CYC - 1))
          begin
            cnt_reg <= '0;
            link_on <= 1'b0;
            state_reg <= PCD_HOST_OFF;
          end
        default:
          state_reg <= PCD_HOST_OFF;
      endcase
    end
  end

endmodule : pcd_host
`default_nettype wire

// ### verif/pcd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_properties #(
  parameter int unsigned OFF_CYC = 200,
  parameter int unsigned PUMP_CYC = 50
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable_dim_pin,
  input wire logic supply_input_low,
  input wire logic over_temp,
  input wire logic regulation_ok,
  input wire logic [3:0] sink_tied_to_pump_output,
  input wire logic [3:0][4:0] sink_level_ma,
  input wire logic [3:0] sink_hiz,
  input wire logic pump_mode_1p5x,
  input wire logic device_enabled,
  input wire logic [4:0] level_setting
);
  int low_cnt;
  int bad_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Raw pin low time and unregulated time
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      low_cnt <= 0;
    else if (enable_dim_pin)
      low_cnt <= 0;
    else if (low_cnt < OFF_CYC + 8)
      low_cnt <= low_cnt + 1;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bad_cnt <= 0;
    else if (regulation_ok || !device_enabled)
      bad_cnt <= 0;
    else if (bad_cnt < PUMP_CYC + 8)
      bad_cnt <= bad_cnt + 1;
  end
  ////////////////////////////////////////
  chk_off_hiz: assert property (!device_enabled |-> sink_hiz == 4'hF)
    else $error("sinks not high impedance in shutdown");
  chk_enable_zero: assert property ($rose(device_enabled) |-> level_setting == 5'h00)
    else $error("level not zero at enable");
  chk_level_step: assert property ($changed(level_setting) && device_enabled && $past(device_enabled) |->
    level_setting == (($past(level_setting) == 5'h00) ? 5'h1F : $past(level_setting) - 5'h01))
    else $error("level moved by a wrong step");
  chk_fall_acts: assert property ($fell(enable_dim_pin) && device_enabled |-> ##[2:8] $changed(level_setting))
    else $error("falling edge not counted");
  chk_long_low: assert property (low_cnt == OFF_CYC + 6 |-> !device_enabled)
    else $error("no shutdown after long low");
  chk_short_low: assert property ($fell(device_enabled) |-> low_cnt >= OFF_CYC)
    else $error("shutdown before low time ran out");
  chk_tied_off: assert property (sink_tied_to_pump_output[0] [*5] |-> sink_level_ma[0] == 5'h00)
    else $error("tied channel carries current");
  chk_other_kept: assert property ((device_enabled && !supply_input_low && !over_temp &&
    !sink_tied_to_pump_output[1] && $stable(level_setting)) [*5] |-> sink_level_ma[1] == level_setting)
    else $error("free channel does not follow level");
  chk_uv_gate: assert property (supply_input_low [*5] |-> sink_level_ma == '0)
    else $error("current flows in undervoltage");
  chk_ot_gate: assert property (over_temp [*5] |-> sink_level_ma == '0)
    else $error("current flows when overheated");
  chk_pump_start: assert property ($rose(device_enabled) |-> !pump_mode_1p5x)
    else $error("pump not in 1x at start");
  chk_pump_late: assert property ($rose(pump_mode_1p5x) |-> bad_cnt + 2 >= PUMP_CYC)
    else $error("pump stepped up too early");
  chk_pump_due: assert property (bad_cnt == PUMP_CYC + 5 |-> pump_mode_1p5x)
    else $error("pump did not step up");
  cover property ($rose(pump_mode_1p5x));
  cover property ($fell(device_enabled));
  cover property ($changed(level_setting) && level_setting == 5'h1F && $past(level_setting) == 5'h00);
endmodule : pcd_properties
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcd_pkg::*;
  localparam int unsigned OFF = 200;
  localparam int unsigned PUMP = 50;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_shutdown = 1'b0;
  logic [5:0] cmd_pulses = 6'h00;
  logic supply_input_low = 1'b0;
  logic over_temp = 1'b0;
  logic regulation_ok = 1'b1;
  logic [3:0] sink_tied_to_pump_output = 4'h0;
  logic [3:0][4:0] sink_level_ma;
  logic [3:0] sink_hiz;
  logic pump_mode_1p5x;
  logic device_enabled;
  logic [4:0] level_setting;
  logic cmd_ready;
  logic link_on;
  logic [4:0] exp_lvl = 5'h00;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 67;
  pcd_link_if link();
  pcd_host #(.LO_CYC(125), .HI_CYC(125), .OFF_CYC(OFF)) pcd_host_i (.clk(clk), .sys_rst(sys_rst),
    .link(link), .cmd_valid(cmd_valid), .cmd_shutdown(cmd_shutdown), .cmd_pulses(cmd_pulses),
    .cmd_ready(cmd_ready), .link_on(link_on));
  pcd_device #(.NUM_CH(4), .OFF_CYC(OFF), .PUMP_CYC(PUMP)) pcd_device_i (.clk(clk), .sys_rst(sys_rst),
    .link(link), .supply_input_low(supply_input_low), .over_temp(over_temp), .regulation_ok(regulation_ok),
    .sink_tied_to_pump_output(sink_tied_to_pump_output), .sink_level_ma(sink_level_ma), .sink_hiz(sink_hiz),
    .pump_mode_1p5x(pump_mode_1p5x), .device_enabled(device_enabled), .level_setting(level_setting));
  pcd_properties #(.OFF_CYC(OFF), .PUMP_CYC(PUMP)) pcd_properties_i (.clk(clk), .sys_rst(sys_rst),
    .enable_dim_pin(link.enable_dim_pin), .supply_input_low(supply_input_low), .over_temp(over_temp),
    .regulation_ok(regulation_ok), .sink_tied_to_pump_output(sink_tied_to_pump_output),
    .sink_level_ma(sink_level_ma), .sink_hiz(sink_hiz), .pump_mode_1p5x(pump_mode_1p5x),
    .device_enabled(device_enabled), .level_setting(level_setting));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      err_count++;
      $display("Error %0t: run hung", $time);
      test_done();
    end
  end
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [4:0] step(input logic [4:0] l);
    return (l == PCD_LEVEL_ZERO) ? PCD_LEVEL_FULL : l - PCD_LEVEL_STEP;
  endfunction : step
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // Hold request until taken, then wait for the host and the pin sync
  task automatic send(input logic sd, input int k);
    cmd_valid = 1'b1;
    cmd_shutdown = sd;
    cmd_pulses = 6'(k);
    while (cmd_ready !== 1'b1) tick();
    tick();
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1) tick();
    repeat (8) tick();
    for (int i = 0; i < k; i++) exp_lvl = sd ? 5'h00 : step(exp_lvl);
  endtask : send
  task automatic chk_sinks(input logic [4:0] lv);
    for (int c = 0; c < 4; c++) check(sink_level_ma[c], sink_tied_to_pump_output[c] ? 5'h00 : lv);
  endtask : chk_sinks
  ////////////////////////////////////////
  initial
  begin
    repeat (16) tick();
    check(5'(sink_hiz), 5'h0F);
    sys_rst = 1'b0;
    tick();
    send(1'b0, 0);
    check(5'(device_enabled), 5'h01);
    check(level_setting, 5'h00);
    chk_sinks(5'h00);
    check(5'(link_on), 5'h01);
    send(1'b0, 32);
    check(level_setting, 5'h00);
    send(1'b0, 1);
    check(level_setting, 5'h1F);
    for (int n = 0; n < 6; n++)
    begin
      sink_tied_to_pump_output = 4'($random(seed));
      send(1'b0, 1 + {$random(seed)} % 40);
      check(level_setting, exp_lvl);
      chk_sinks(exp_lvl);
    end
    for (int n = 0; n < 2; n++)
    begin
      {over_temp, supply_input_low} = (n == 0) ? 2'h1 : 2'h2;
      repeat (8) tick();
      chk_sinks(5'h00);
      {over_temp, supply_input_low} = 2'h0;
      repeat (8) tick();
      chk_sinks(exp_lvl);
    end
    regulation_ok = 1'b0;
    repeat (PUMP - 10) tick();
    check(5'(pump_mode_1p5x), 5'h00);
    repeat (20) tick();
    check(5'(pump_mode_1p5x), 5'h01);
    regulation_ok = 1'b1;
    send(1'b1, 0);
    check(5'(device_enabled), 5'h00);
    check(5'(sink_hiz), 5'h0F);
    exp_lvl = 5'h00;
    send(1'b0, 0);
    check(5'(pump_mode_1p5x), 5'h00);
    check(level_setting, 5'h00);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
